// [rtl/dbsc_regs.sv]
// APB register bank holding DRAM bank sizes, types and geometry
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module dbsc_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output dbsc_pkg::dbsc_bank_cfg_t [7:0] bank_cfg
);

  //////////////////////////////////////////////////////////////////////////
  // Address decode

  // True when an address is the aligned word of a register index
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] idx);
    idx_hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction : idx_hit

  // Register storage
  logic [7:0] reg_ff [dbsc_pkg::NUM_REGS];
  // Bus answer flops
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  // Registered bank outputs
  dbsc_pkg::dbsc_bank_cfg_t [7:0] bank_cfg_ff;

  // Setup phase and committing access phase
  wire logic setup = psel & ~penable;
  wire logic commit = psel & penable & pready_ff;
  wire logic wr_commit = commit & pwrite & pstrb[0];

  // One select per register slot
  wire logic [dbsc_pkg::NUM_REGS-1:0] sel;
  // Read data accumulated across slots
  wire logic [7:0] rd_acc [dbsc_pkg::NUM_REGS+1];
  assign rd_acc[0] = 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < dbsc_pkg::NUM_REGS; gi++) begin : g_sel
      // Slot decode and read mux chain
      assign sel[gi] = idx_hit(paddr, dbsc_pkg::REG_IDX[gi]);
      assign rd_acc[gi+1] = rd_acc[gi] | (sel[gi] ? reg_ff[gi] : 8'h00);
    end
  endgenerate

  // Any register selected
  wire logic mapped = |sel;
  wire logic [7:0] rd_byte = rd_acc[dbsc_pkg::NUM_REGS];

  //////////////////////////////////////////////////////////////////////////
  // Registers

  generate
    for (gi = 0; gi < dbsc_pkg::NUM_REGS; gi++) begin : g_reg
      // Byte lane zero carries the register, upper lanes are dropped
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          reg_ff[gi] <= dbsc_pkg::CFG_RESET;
        end else if (wr_commit && sel[gi]) begin
          reg_ff[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // APB answer

  // Answer prepared in setup so access phase has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff <= (setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0;
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  //////////////////////////////////////////////////////////////////////////
  // Bank decode

  // Combinational per-bank settings
  dbsc_pkg::dbsc_bank_cfg_t dec_cfg [dbsc_pkg::NUM_BANKS];

  generate
    for (gi = 0; gi < dbsc_pkg::NUM_BANKS; gi++) begin : g_bank
      // Even banks in low nibble, odd banks in high nibble
      dbsc_bank_decode u_dec (
        .nibble(reg_ff[gi/2][dbsc_pkg::NIBBLE_W*(gi%2) +: 4]),
        .geom_bit(reg_ff[dbsc_pkg::GEOM_SLOT][gi]),
        .cfg(dec_cfg[gi])
      );
    end
  endgenerate

  // Outputs leave from flops; one process owns the whole packed vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_cfg_ff <= '0;
    end else begin
      for (int b = 0; b < dbsc_pkg::NUM_BANKS; b++) begin
        bank_cfg_ff[b] <= dec_cfg[b];
      end
    end
  end

  assign bank_cfg = bank_cfg_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  // Expected megabytes for bank 0 from its stored code
  wire logic [2:0] chk_code0 = reg_ff[0][2:0];
  wire logic [6:0] chk_mb0 = (chk_code0 == 3'h0) ? 7'h00 :
    (7'h01 << (chk_code0 - 3'h1));

  chk_size_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 (bank_cfg_ff[0].size_mb == $past(chk_mb0)) &&
        (bank_cfg_ff[0].present == ($past(chk_code0) != 3'h0)))
    else $error("bank 0 size decode wrong");

  chk_bank01_layout: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_commit && sel[0]) |-> ##2
      (bank_cfg_ff[1].size_code == $past(pwdata[6:4], 2)) &&
      (bank_cfg_ff[0].size_code == $past(pwdata[2:0], 2)))
    else $error("banks 0 and 1 layout wrong");

  chk_bank23_layout: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_commit && sel[1]) |-> ##2
      (bank_cfg_ff[3].size_code == $past(pwdata[6:4], 2)) &&
      (bank_cfg_ff[2].size_code == $past(pwdata[2:0], 2)))
    else $error("banks 2 and 3 layout wrong");

  chk_bank45_layout: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_commit && sel[2]) |-> ##2
      (bank_cfg_ff[5].size_code == $past(pwdata[6:4], 2)) &&
      (bank_cfg_ff[4].size_code == $past(pwdata[2:0], 2)))
    else $error("banks 4 and 5 layout wrong");

  chk_bank67_layout: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_commit && sel[3]) |-> ##2
      (bank_cfg_ff[7].size_code == $past(pwdata[6:4], 2)) &&
      (bank_cfg_ff[6].size_code == $past(pwdata[2:0], 2)))
    else $error("banks 6 and 7 layout wrong");

  chk_geom_select: assert property (
    @(posedge pclk) disable iff (!presetn)
    (reg_ff[0][3] && $stable(reg_ff[0]) && $stable(reg_ff[4])) |=>
      (bank_cfg_ff[0].geom == ($past(reg_ff[4][0]) ?
        dbsc_pkg::DBSC_GEOM_12X8 : dbsc_pkg::DBSC_GEOM_11X9)))
    else $error("bank 0 geometry wrong");

  chk_sym_ignores: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!reg_ff[1][7]) |=> (bank_cfg_ff[3].geom == dbsc_pkg::DBSC_GEOM_SYM))
    else $error("symmetric bank 3 shows geometry");

  chk_reset_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> (bank_cfg_ff == '0) && (reg_ff[4] == 8'h00))
    else $error("state not clear after reset");

  chk_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready && (pslverr == !$past(mapped)) ##1 !pready)
    else $error("bus answer timing wrong");

  // A write without lane zero strobe leaves the register alone
  chk_strobe_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    (commit && pwrite && !pstrb[0] && sel[0]) |=>
      (reg_ff[0] == $past(reg_ff[0])))
    else $error("write without lane strobe changed a register");

  // Refused reads flag an error and return zero
  chk_refused_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && !mapped) |=> pslverr && (prdata == 32'h0))
    else $error("refused read returned data");

  // Geometry register reads back what is stored
  chk_read_geometry: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && sel[dbsc_pkg::GEOM_SLOT]) |=>
      (prdata == {24'h00_0000, $past(reg_ff[dbsc_pkg::GEOM_SLOT])}))
    else $error("geometry register read back wrong");

  // Asymmetric bank with geometry bit set uses 12 rows by 8 columns
  chk_bank5_geometry: assert property (
    @(posedge pclk) disable iff (!presetn)
    (reg_ff[2][7] && reg_ff[4][5]) |=>
      (bank_cfg_ff[5].geom == dbsc_pkg::DBSC_GEOM_12X8))
    else $error("asymmetric bank 5 geometry wrong");

  // Largest size code gives 64 megabytes
  chk_size_top: assert property (
    @(posedge pclk) disable iff (!presetn)
    (reg_ff[0][6:4] == 3'h7) |=> (bank_cfg_ff[1].size_mb == 7'h40))
    else $error("bank 1 largest size wrong");

endmodule : dbsc_regs

// [rtl/dbsc_pkg.sv]
// Constants and carrier types for the DRAM bank size configuration block
package dbsc_pkg;

  // Bank count and register count
  localparam int NUM_BANKS = 8;
  localparam int NUM_REGS = 5;

  // Register indexes; byte address on APB is four times the index
  localparam logic [7:0] IDX_BANKS01 = 8'h32;
  localparam logic [7:0] IDX_BANKS23 = 8'h33;
  localparam logic [7:0] IDX_BANKS45 = 8'h34;
  localparam logic [7:0] IDX_BANKS67 = 8'h35;
  localparam logic [7:0] IDX_GEOMETRY = 8'h36;

  // Index table, entry i is register slot i
  localparam logic [4:0][7:0] REG_IDX = {IDX_GEOMETRY, IDX_BANKS67,
    IDX_BANKS45, IDX_BANKS23, IDX_BANKS01};

  // Slot of the asymmetric geometry register
  localparam int GEOM_SLOT = 4;

  // Reset value of every register
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Field layout inside one bank nibble
  localparam int SIZE_LSB = 0;
  localparam int SIZE_W = 3;
  localparam int TYPE_BIT = 3;
  localparam int NIBBLE_W = 4;

  // Size code meaning no memory present
  localparam logic [2:0] SIZE_NONE = 3'h0;

  // Bank addressing geometry, Gray coded
  typedef enum logic [1:0] {
    DBSC_GEOM_SYM = 2'b00,
    DBSC_GEOM_11X9 = 2'b01,
    DBSC_GEOM_12X8 = 2'b11
  } dbsc_geom_t;

  // Decoded configuration of one bank
  typedef struct packed {
    logic present;
    logic [2:0] size_code;
    logic [6:0] size_mb;
    dbsc_geom_t geom;
  } dbsc_bank_cfg_t;

endpackage : dbsc_pkg

// [rtl/dbsc_bank_decode.sv]
// Decoder turning one bank nibble and geometry bit into bank settings
`timescale 1ns/1ns
module dbsc_bank_decode (
  input wire logic [3:0] nibble,
  input wire logic geom_bit,
  output dbsc_pkg::dbsc_bank_cfg_t cfg
);

  // Size code and type flag out of the nibble
  wire logic [2:0] size_code = nibble[dbsc_pkg::SIZE_LSB +: dbsc_pkg::SIZE_W];
  wire logic type_asym = nibble[dbsc_pkg::TYPE_BIT];

  // Zero means absent, else megabytes double per code step
  wire logic present = (size_code != dbsc_pkg::SIZE_NONE);
  wire logic [6:0] size_mb = present ?
    (7'h01 << (size_code - 3'h1)) : 7'h00;

  // Symmetric banks ignore the geometry bit
  wire dbsc_pkg::dbsc_geom_t geom = !type_asym ? dbsc_pkg::DBSC_GEOM_SYM :
    (geom_bit ? dbsc_pkg::DBSC_GEOM_12X8 :
     dbsc_pkg::DBSC_GEOM_11X9);

  // Pack the result
  assign cfg = '{present: present, size_code: size_code,
                 size_mb: size_mb, geom: geom};

endmodule : dbsc_bank_decode

// [tb/tb.sv]
// Self-checking bench for the DRAM bank configuration registers
`timescale 1ns/1ns
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  dbsc_pkg::dbsc_bank_cfg_t [7:0] bank_cfg;
  int err_total = 0;
  int checks_done = 0;
  // Expected register contents, slot 4 is geometry
  logic [7:0] cur [5] = '{default: 8'h00};
  logic [7:0] val [4] = '{8'hc9, 8'h3b, 8'hed, 8'h5f};
  // Megabytes for each size code, code zero means no memory
  logic [6:0] mb_tab [8] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10,
    7'h20, 7'h40};

  always #10 pclk = ~pclk;

  dbsc_regs #(.ADDR_W(12)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bank_cfg(bank_cfg));

  ////////////////////////////////////////////////////////////////////////
  // Final verdict, ends the run
  task automatic summarize();
    $display("Checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d, input logic [3:0] s, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Write one register slot and track it
  task automatic wreg(input int i, input logic [7:0] d);
    apb(1'b1, {2'b00, dbsc_pkg::REG_IDX[i], 2'b00}, d, 4'h1, rd, er);
    cur[i] = d;
    chk("write pslverr", 32'h0, {31'h0, er});
  endtask : wreg

  // Read back every register slot
  task automatic rd_all();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, {2'b00, dbsc_pkg::REG_IDX[i], 2'b00}, 8'h00, 4'h0, rd, er);
      chk("readback", {24'h0, cur[i]}, rd);
    end
  endtask : rd_all

  // Expected decode of one bank nibble
  function automatic dbsc_pkg::dbsc_bank_cfg_t exp_cfg(
    input logic [3:0] n, input logic g);
    dbsc_pkg::dbsc_bank_cfg_t c;
    c.present = (n[2:0] != 3'h0);
    c.size_code = n[2:0];
    c.size_mb = mb_tab[n[2:0]];
    c.geom = !n[3] ? dbsc_pkg::DBSC_GEOM_SYM :
      (g ? dbsc_pkg::DBSC_GEOM_12X8 : dbsc_pkg::DBSC_GEOM_11X9);
    return c;
  endfunction : exp_cfg

  // Check all eight bank outputs after the update latency
  task automatic chk_banks();
    logic [3:0] n;
    repeat (2) @(posedge pclk);
    #1;
    for (int b = 0; b < 8; b++) begin
      n = 4'(cur[b/2] >> (4 * (b % 2)));
      chk("bank_cfg", 32'(exp_cfg(n, cur[4][b])), 32'(bank_cfg[b]));
    end
  endtask : chk_banks

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_all();
    chk_banks();
    $display("Test reset values done");
    for (int k = 0; k < 8; k++) begin
      wreg(0, {1'(k), 3'(7 - k), 1'(k + 1), 3'(k)});
      chk_banks();
    end
    rd_all();
    $display("Test size codes done");
    wreg(4, 8'ha5);
    for (int r = 0; r < 4; r++) wreg(r, val[r]);
    chk_banks();
    rd_all();
    $display("Test layout and geometry done");
    apb(1'b1, 12'h0c8, 8'h00, 4'h0, rd, er);
    chk("strobe-less pslverr", 32'h0, {31'h0, er});
    apb(1'b0, 12'h0dc, 8'h00, 4'h1, rd, er);
    chk("unmapped pslverr", 32'h1, {31'h0, er});
    chk("unmapped prdata", 32'h0, rd);
    apb(1'b1, 12'h0c9, 8'hff, 4'h1, rd, er);
    chk("misaligned pslverr", 32'h1, {31'h0, er});
    rd_all();
    $display("Test refused accesses done");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    cur = '{default: 8'h00};
    rd_all();
    chk_banks();
    $display("Test second reset done");
    summarize();
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    err_total++;
    summarize();
  end
endmodule : tb
